// ---- rtl/srrc_pkg.sv ----
// Purpose : Shared constants for the standby release and reset control
// Assumes : Block clock is the main system clock (one cycle = 1/main_osc_freq)
// Notes   : Long settle counts are parameters of the top module instead

package srrc_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [15:0] SRRC_ADDR_SETTLE  = 16'hFFFA; // Settle select
    localparam logic [15:0] SRRC_ADDR_STATUS  = 16'hFFFB; // Mode status
    localparam logic [7:0]  SRRC_SETTLE_RST   = 8'h04;    // Value after reset
    localparam int          SRRC_SETTLE_W     = 3;        // Select field width

    // Settle select codes
    localparam logic [2:0]  SRRC_SEL_SHORT    = 3'h0;     // 2^12 periods
    localparam logic [2:0]  SRRC_SEL_MID      = 3'h2;     // 2^15 periods
    localparam logic [2:0]  SRRC_SEL_LONG     = 3'h4;     // 2^17 periods

    // ==========================================================
    // Timing (main clock periods)
    // ==========================================================
    localparam int          SRRC_CNT_W        = 18;       // Settle counter
    localparam int unsigned SRRC_SHORT_CYC    = 4096;     // 2^12 periods
    localparam int unsigned SRRC_MID_CYC      = 32768;    // 2^15 periods
    localparam int unsigned SRRC_LONG_CYC     = 131072;   // 2^17 periods

    // ==========================================================
    // Reset vector table
    // ==========================================================
    localparam logic [15:0] SRRC_VEC_LO       = 16'h0000; // Low byte slot
    localparam logic [15:0] SRRC_VEC_HI       = 16'h0001; // High byte slot

    // ==========================================================
    // Controller states, one-hot
    // ==========================================================
    typedef enum logic [5:0] {
        SRRC_RUN     = 6'h01, // CPU executing
        SRRC_HALT    = 6'h02, // CPU clock gated, oscillator on
        SRRC_STOP    = 6'h04, // Oscillator off
        SRRC_SETTLE  = 6'h08, // Wait after stop release by interrupt
        SRRC_RESET   = 6'h10, // Reset input active
        SRRC_RSETTLE = 6'h20  // Wait after reset release
    } srrc_state_e;

endpackage

// ---- rtl/srrc_standby_reset.sv ----
// Purpose : Standby (halt/stop) release and reset sequencing controller
// Assumes : All inputs synchronous except the reset pin, which is synced
// Notes   : Settle counts above 4096 cycles are overridable parameters
//
// Chosen here: strobed register access and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module srrc_standby_reset #(
    parameter int unsigned MID_CYCLES  = srrc_pkg::SRRC_MID_CYC,
    parameter int unsigned LONG_CYCLES = srrc_pkg::SRRC_LONG_CYC
) (
    input  wire logic        clock,             // Main system clock
    input  wire logic        srst,              // Power-on reset, sync
    input  wire logic        reset_pin_n,       // External reset pin
    input  wire logic        wdt_overflow,      // Watchdog overflow pulse
    input  wire logic        halt_exec,         // Halt instruction pulse
    input  wire logic        stop_exec,         // Stop instruction pulse
    input  wire logic        irq_unmasked,      // Request with mask 0
    input  wire logic        nmi_req,           // Non-maskable request
    input  wire logic        interrupt_accept_enable, // Acceptance flag
    input  wire logic        osc_started,       // Oscillation running
    input  wire logic        sub_clk_running,   // Subsystem clock runs
    input  wire logic        sub_clk_selected,  // Subsystem clock is CPU clk
    input  wire logic [15:0] reg_addr,          // Register address
    input  wire logic [7:0]  reg_wdata,         // Register write data
    input  wire logic        reg_wr,            // Write strobe
    input  wire logic        reg_rd,            // Read strobe
    output logic      [7:0]  reg_rdata,         // Read data, next cycle
    output logic             cpu_run,           // CPU clock enable
    output logic             osc_enable,        // Main oscillator enable
    output logic             crystal_out_pin_pullup, // Pull-up on crystal out
    output logic             pins_hiz,          // All pins high impedance
    output logic             sys_reset,         // Hardware reset to chip
    output logic             load_reset_vector, // Pulse: fetch vector
    output logic      [15:0] reset_vector_addr, // Vector table address
    output logic             resume_next,       // Pulse: next instruction
    output logic             service_irq,       // Pulse: vectored service
    output logic             port_latch_hold,   // Port latches frozen
    output logic             main_periph_enable,// Timers, WDT, serial
    output logic             watch_lcd_enable,  // Watch timer and LCD
    output logic             pulse_clk_enable,  // Pulse clock output
    output logic             ext_irq_detect     // External irq detection
);

    // ==========================================================
    // Declarations
    // ==========================================================
    logic                 pin_meta_q;     // Sync stage 1
    logic                 pin_sync_q;     // Sync stage 2
    logic                 reset_req;      // Any reset source active
    srrc_pkg::srrc_state_e state_q;       // Controller state
    srrc_pkg::srrc_state_e state_d;       // Next state
    logic                 stop_hold_q;    // Reset arrived during stop
    logic                 stop_hold_d;
    logic [2:0]           settle_sel_q;   // Settle select register
    logic [srrc_pkg::SRRC_CNT_W-1:0] cnt_q;     // Settle counter
    logic [srrc_pkg::SRRC_CNT_W-1:0] target_q;  // Last count value
    logic [srrc_pkg::SRRC_CNT_W-1:0] target_d;
    logic [srrc_pkg::SRRC_CNT_W-1:0] sel_target; // From select code
    logic                 cnt_done;       // Settle wait over
    logic                 accept_q;       // Acceptance latched at release
    logic                 accept_d;
    logic                 vec_d;          // Pulse next values
    logic                 next_d;
    logic                 svc_d;

    // Local names for the package state codes
    localparam srrc_pkg::srrc_state_e
        SRRC_RUN     = srrc_pkg::SRRC_RUN,
        SRRC_HALT    = srrc_pkg::SRRC_HALT,
        SRRC_STOP    = srrc_pkg::SRRC_STOP,
        SRRC_SETTLE  = srrc_pkg::SRRC_SETTLE,
        SRRC_RESET   = srrc_pkg::SRRC_RESET,
        SRRC_RSETTLE = srrc_pkg::SRRC_RSETTLE;

    // ==========================================================
    // Reset pin synchroniser and reset sources
    // ==========================================================
    // pin synchroniser
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
        end else begin
            pin_meta_q <= reset_pin_n;
            pin_sync_q <= pin_meta_q;
        end
    end

    // two reset sources
    // One-cycle watchdog pulse clears itself
    assign reset_req = ~pin_sync_q | wdt_overflow;

    // ==========================================================
    // Settle select register
    // ==========================================================
    // select map, illegal codes take the longest wait
    always_comb begin
        case (settle_sel_q)
            srrc_pkg::SRRC_SEL_SHORT:
                sel_target = srrc_pkg::SRRC_CNT_W'(srrc_pkg::SRRC_SHORT_CYC-1);
            srrc_pkg::SRRC_SEL_MID:
                sel_target = srrc_pkg::SRRC_CNT_W'(MID_CYCLES - 1);
            default:
                sel_target = srrc_pkg::SRRC_CNT_W'(LONG_CYCLES - 1);
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst || sys_reset) begin
            // Hardware reset restores the default code
            settle_sel_q <= srrc_pkg::SRRC_SETTLE_RST[2:0];
        end else if (reg_wr && reg_addr == srrc_pkg::SRRC_ADDR_SETTLE) begin
            // Prohibited codes are ignored
            if (reg_wdata[2:0] == srrc_pkg::SRRC_SEL_SHORT ||
                reg_wdata[2:0] == srrc_pkg::SRRC_SEL_MID ||
                reg_wdata[2:0] == srrc_pkg::SRRC_SEL_LONG) begin
                settle_sel_q <= reg_wdata[2:0];
            end
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == srrc_pkg::SRRC_ADDR_SETTLE) begin
            reg_rdata <= {5'h00, settle_sel_q};
        end else if (reg_rd && reg_addr == srrc_pkg::SRRC_ADDR_STATUS) begin
            reg_rdata <= {2'h0, state_q};
        end else begin
            // Unmapped or idle reads as zero
            reg_rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Settle counter
    // ==========================================================
    assign cnt_done = (cnt_q == target_q);

    // count only once oscillation has started
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (state_d != state_q) begin
            // Fresh wait on every state change
            cnt_q <= '0;
        end else if ((state_q == SRRC_SETTLE || state_q == SRRC_RSETTLE)
                     && osc_started && !cnt_done) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Target and release flavour held through the wait
    always_ff @(posedge clock) begin
        if (srst) begin
            target_q <= srrc_pkg::SRRC_CNT_W'(MID_CYCLES - 1);
            accept_q <= 1'b0;
            stop_hold_q <= 1'b0;
        end else begin
            target_q <= target_d;
            accept_q <= accept_d;
            stop_hold_q <= stop_hold_d;
        end
    end

    // ==========================================================
    // Next state and event pulses
    // ==========================================================
    always_comb begin
        state_d     = state_q;
        target_d    = target_q;
        accept_d    = accept_q;
        stop_hold_d = stop_hold_q;
        vec_d       = 1'b0;
        next_d      = 1'b0;
        svc_d       = 1'b0;
        case (state_q)
            SRRC_RUN: begin
                if (reset_req) begin
                    state_d = SRRC_RESET;
                end else if (stop_exec && irq_unmasked) begin
                    // pending request: oscillator kept, wait anyway
                    state_d  = SRRC_SETTLE;
                    target_d = sel_target;
                    accept_d = interrupt_accept_enable;
                end else if (stop_exec) begin
                    state_d = SRRC_STOP;
                end else if (halt_exec) begin
                    state_d = SRRC_HALT;
                end
            end
            SRRC_HALT: begin
                // halt release priority: reset, NMI, unmasked
                if (reset_req) begin
                    // reset goes through the normal reset path
                    state_d = SRRC_RESET;
                end else if (nmi_req) begin
                    state_d = SRRC_RUN;
                    svc_d   = 1'b1;
                end else if (irq_unmasked) begin
                    state_d = SRRC_RUN;
                    svc_d   = interrupt_accept_enable;
                    next_d  = ~interrupt_accept_enable;
                end
            end
            SRRC_STOP: begin
                // stop release: reset, else unmasked request
                if (reset_req) begin
                    // contents held while reset input lasts
                    state_d     = SRRC_RESET;
                    stop_hold_d = 1'b1;
                end else if (irq_unmasked) begin
                    state_d  = SRRC_SETTLE;
                    target_d = sel_target;
                    accept_d = interrupt_accept_enable;
                end
            end
            SRRC_SETTLE: begin
                if (reset_req) begin
                    state_d = SRRC_RESET;
                end else if (cnt_done) begin
                    // service only after the settle wait
                    state_d = SRRC_RUN;
                    svc_d   = accept_q;
                    next_d  = ~accept_q;
                end
            end
            SRRC_RESET: begin
                if (!reset_req) begin
                    state_d  = SRRC_RSETTLE;
                    target_d = srrc_pkg::SRRC_CNT_W'(MID_CYCLES - 1);
                end
            end
            SRRC_RSETTLE: begin
                if (reset_req) begin
                    state_d = SRRC_RESET;
                end else if (cnt_done) begin
                    // run from the vector after the wait
                    state_d     = SRRC_RUN;
                    stop_hold_d = 1'b0;
                    vec_d       = 1'b1;
                end
            end
            default: begin
                state_d = SRRC_RESET;
            end
        endcase
    end

    // State register, power-on enters the reset state
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= SRRC_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    // Release pulses and vector
    always_ff @(posedge clock) begin
        if (srst) begin
            load_reset_vector <= 1'b0;
            resume_next       <= 1'b0;
            service_irq       <= 1'b0;
            reset_vector_addr <= srrc_pkg::SRRC_VEC_LO;
        end else begin
            // vector table at 0000H/0001H for both sources
            load_reset_vector <= vec_d;
            resume_next       <= next_d;
            service_irq       <= svc_d;
            reset_vector_addr <= srrc_pkg::SRRC_VEC_LO;
        end
    end

    // Clocking, pin and reset controls
    always_ff @(posedge clock) begin
        if (srst) begin
            cpu_run                <= 1'b0;
            osc_enable             <= 1'b1;
            crystal_out_pin_pullup <= 1'b0;
            pins_hiz               <= 1'b1;
            sys_reset              <= 1'b1;
        end else begin
            // CPU only runs in run state
            cpu_run <= (state_d == SRRC_RUN);
            // oscillator off in stop and in reset held from stop
            osc_enable <= !(state_d == SRRC_STOP ||
                            (state_d == SRRC_RESET && stop_hold_d));
            // pull-up while the oscillator is stopped
            crystal_out_pin_pullup <= !(state_d != SRRC_STOP &&
                !(state_d == SRRC_RESET && stop_hold_d));
            // pins float during reset and its wait
            pins_hiz <= (state_d == SRRC_RESET || state_d == SRRC_RSETTLE);
            // hardware reset, but stop contents kept on input
            sys_reset <= (state_d == SRRC_RSETTLE) ||
                         (state_d == SRRC_RESET && !stop_hold_d);
        end
    end

    // Peripheral enables during standby
    always_ff @(posedge clock) begin
        if (srst) begin
            port_latch_hold    <= 1'b0;
            main_periph_enable <= 1'b0;
            watch_lcd_enable   <= 1'b0;
            pulse_clk_enable   <= 1'b0;
            ext_irq_detect     <= 1'b0;
        end else begin
            port_latch_hold <= (state_d == SRRC_HALT ||
                                state_d == SRRC_STOP);
            // timers, watchdog, serial halted in stop
            main_periph_enable <= (state_d == SRRC_RUN ||
                                   state_d == SRRC_HALT);
            // subclock keeps watch, LCD and pulse out alive
            watch_lcd_enable <= (state_d == SRRC_RUN ||
                                 state_d == SRRC_HALT) ||
                ((state_d == SRRC_STOP) && sub_clk_running &&
                 sub_clk_selected);
            pulse_clk_enable <= (state_d == SRRC_RUN ||
                                 state_d == SRRC_HALT) ||
                ((state_d == SRRC_STOP) && sub_clk_running &&
                 sub_clk_selected);
            ext_irq_detect <= !(state_d == SRRC_RESET ||
                                state_d == SRRC_RSETTLE);
        end
    end

endmodule

`default_nettype wire

// ---- test/srrc_props.sv ----
// Purpose: Port-level assertions for standby and reset control
// Assumes: One clock domain, synchronous active-high srst
// Notes:   Bound onto every srrc_standby_reset instance
`timescale 1ns/1ps
`default_nettype none
module srrc_props #(
    parameter int unsigned MID_CYCLES = 32768
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic reset_pin_n,
    input wire logic wdt_overflow,
    input wire logic stop_exec,
    input wire logic irq_unmasked,
    input wire logic nmi_req,
    input wire logic interrupt_accept_enable,
    input wire logic osc_started,
    input wire logic sub_clk_running,
    input wire logic sub_clk_selected,
    input wire logic cpu_run,
    input wire logic osc_enable,
    input wire logic crystal_out_pin_pullup,
    input wire logic pins_hiz,
    input wire logic sys_reset,
    input wire logic load_reset_vector,
    input wire logic resume_next,
    input wire logic service_irq,
    input wire logic port_latch_hold,
    input wire logic main_periph_enable,
    input wire logic watch_lcd_enable,
    input wire logic pulse_clk_enable,
    input wire logic ext_irq_detect
);
    // ==================================================
    // Helpers: pin history, state decode, settle count
    // ==================================================
    logic [1:0]  pin_q;  // Last two pin samples
    logic [17:0] wait_q; // Counted cycles in reset settle
    wire quiet   = reset_pin_n & (&pin_q) & !wdt_overflow;
    wire in_halt = !cpu_run & main_periph_enable;
    wire in_stop = !osc_enable & !pins_hiz;
    wire sub_on  = sub_clk_running & sub_clk_selected;
    // Pin history keeps the synchroniser lag out of view
    always_ff @(posedge clock) begin
        if (srst) pin_q <= 2'h0;
        else pin_q <= {pin_q[0], reset_pin_n};
    end
    // Counts oscillating cycles once reset sources are gone
    always_ff @(posedge clock) begin
        if (srst || !quiet || !pins_hiz) wait_q <= 18'h00000;
        else if (osc_started) wait_q <= wait_q + 18'h00001;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // ==================================================
    // Assertions
    // ==================================================
    pullup_stop_a: assert property (
        crystal_out_pin_pullup == !osc_enable)
        else $error("pull-up does not track oscillator off");
    stop_entry_a: assert property (
        cpu_run && stop_exec && !irq_unmasked && quiet |=> in_stop)
        else $error("stop not entered");
    stop_pending_a: assert property (
        cpu_run && stop_exec && irq_unmasked && quiet
        |=> osc_enable && !cpu_run && !port_latch_hold)
        else $error("pending request did not skip the stop");
    stop_outputs_a: assert property (
        in_stop |-> port_latch_hold && ext_irq_detect && !main_periph_enable
        && watch_lcd_enable == $past(sub_on) && pulse_clk_enable == $past(sub_on))
        else $error("wrong enables while stopped");
    stop_keep_a: assert property (
        in_stop && !irq_unmasked && quiet |=> in_stop)
        else $error("stop left without cause");
    halt_nmi_a: assert property (
        in_halt && nmi_req && quiet |=> cpu_run && service_irq)
        else $error("nmi did not service from halt");
    halt_irq_a: assert property (
        in_halt && !nmi_req && irq_unmasked && quiet |=> cpu_run
        && service_irq == $past(interrupt_accept_enable)
        && resume_next != $past(interrupt_accept_enable))
        else $error("wrong halt release by request");
    halt_keep_a: assert property (
        in_halt && !nmi_req && !irq_unmasked && quiet |=> in_halt)
        else $error("halt left without cause");
    wdt_reset_a: assert property (
        cpu_run && wdt_overflow |=> sys_reset && pins_hiz && !cpu_run)
        else $error("watchdog overflow did not reset");
    reset_stop_a: assert property (
        pins_hiz && !sys_reset |-> !osc_enable && !cpu_run)
        else $error("reset in stop disturbed stop state");
    vector_load_a: assert property (
        load_reset_vector |-> cpu_run && $past(pins_hiz)
        && wait_q >= MID_CYCLES - 2 && wait_q <= MID_CYCLES + 6)
        else $error("vector fetch without full settle wait");
endmodule
bind srrc_standby_reset srrc_props #(.MID_CYCLES(MID_CYCLES)) u_props (.*);
`default_nettype wire

// ---- test/srrc_osc_model.sv ----
// Purpose: Main oscillator model at the far side of the block
// Assumes: Oscillation starts a fixed lag after enable
// Notes:   Stops at once when the enable drops
`timescale 1ns/1ps
`default_nettype none
module srrc_osc_model #(
    parameter int unsigned START_DLY = 6
) (
    input  wire logic clock,
    input  wire logic osc_enable,
    output logic      osc_started
);
    logic [7:0] dly_q = 8'h00; // Cycles since enable
    // start lag that the settle wait must exclude
    always_ff @(posedge clock) begin
        if (!osc_enable) dly_q <= 8'h00;
        else if (dly_q != START_DLY[7:0]) dly_q <= dly_q + 8'h01;
    end
    assign osc_started = osc_enable && (dly_q == START_DLY[7:0]);
endmodule
`default_nettype wire

// ---- test/srrc_standby_reset_tb.sv ----
// Purpose: Self-checking bench for standby and reset control
// Assumes: Shortened settle counts, oscillator lag of DLY cycles
// Notes:   Drives on rising edges, samples on falling edges
`timescale 1ns/1ps
`default_nettype none
module srrc_standby_reset_tb;
    localparam int MID  = 64;  // Shortened 2^15 wait
    localparam int LONG = 128; // Shortened 2^17 wait
    localparam int DLY  = 6;   // Oscillator start lag
    localparam logic [15:0] SEL = 16'hFFFA;
    logic clock = 1'b0, srst = 1'b1, reset_pin_n = 1'b1;
    logic wdt_overflow = 1'b0, halt_exec = 1'b0, stop_exec = 1'b0;
    logic irq_unmasked = 1'b0, nmi_req = 1'b0;
    logic interrupt_accept_enable = 1'b0, osc_started;
    logic sub_clk_running = 1'b1, sub_clk_selected = 1'b0;
    logic [15:0] reg_addr = 16'h0000, reset_vector_addr;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_run, osc_enable, pins_hiz;
    logic crystal_out_pin_pullup, sys_reset, load_reset_vector;
    logic resume_next, service_irq, port_latch_hold, main_periph_enable;
    logic watch_lcd_enable, pulse_clk_enable, ext_irq_detect;
    int err_total = 0, n_compared = 0;
    always #10 clock = ~clock;
    srrc_standby_reset #(.MID_CYCLES(MID), .LONG_CYCLES(LONG)) u_dut (.*);
    srrc_osc_model #(.START_DLY(DLY)) u_osc (.*);
    // ==================================================
    // Shared tasks
    // ==================================================
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait: 0 service, 1 resume, 2 vector fetch
    task automatic wait_ev(input int which, input int lo, input int hi);
        int n;
        logic ev;
        n = 0;
        ev = 1'b0;
        while (ev !== 1'b1 && n <= hi) begin
            @(negedge clock);
            n++;
            ev = which == 0 ? service_irq :
                 which == 1 ? resume_next : load_reset_vector;
        end
        chk({15'h0000, n >= lo && n <= hi}, 16'h0001);
        if (n > hi) test_done();
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    // One-cycle pulse: 0 halt, 1 stop, 2 watchdog
    task automatic pulse(input int which);
        @(posedge clock);
        halt_exec <= (which == 0);
        stop_exec <= (which == 1);
        wdt_overflow <= (which == 2);
        @(posedge clock);
        halt_exec <= 1'b0;
        stop_exec <= 1'b0;
        wdt_overflow <= 1'b0;
        @(negedge clock);
    endtask
    task automatic go_stop(input logic [2:0] code, input logic sub);
        wr(SEL, {5'h00, code});
        sub_clk_selected <= sub;
        pulse(1);
        chk({12'h000, osc_enable, crystal_out_pin_pullup, cpu_run,
             main_periph_enable}, 16'h0004);
        chk({12'h000, port_latch_hold, ext_irq_detect, watch_lcd_enable,
             pulse_clk_enable}, {12'h000, 2'b11, sub, sub});
    endtask
    task automatic unstop(input int which, input logic acc, int lo, hi);
        @(posedge clock);
        irq_unmasked <= 1'b1;
        interrupt_accept_enable <= acc;
        wait_ev(which, lo, hi);
        @(posedge clock);
        irq_unmasked <= 1'b0;
    endtask
    // Pin held low 520 cycles, over the 10 us minimum
    task automatic pin_reset(input logic [3:0] exp);
        @(posedge clock);
        reset_pin_n <= 1'b0;
        repeat (520) @(negedge clock);
        chk({12'h000, osc_enable, sys_reset, pins_hiz, cpu_run},
            {12'h000, exp});
        @(posedge clock);
        reset_pin_n <= 1'b1;
    endtask
    // ==================================================
    // Scenarios
    // ==================================================
    task automatic t_power_up;
        wait_ev(2, MID, MID + DLY + 12);
        chk(reset_vector_addr, 16'h0000);
        rd(SEL, 8'h04);
        rd(16'hFFF0, 8'h00);
    endtask
    task automatic t_select;
        for (int i = 0; i < 3; i++) begin
            wr(SEL, 8'(2 * i));
            rd(SEL, 8'(2 * i));
        end
        wr(SEL, 8'h03);
        rd(SEL, 8'h04);
    endtask
    task automatic t_halt;
        for (int k = 0; k < 3; k++) begin
            pulse(0);
            rd(16'hFFFB, 8'h02);
            @(posedge clock);
            irq_unmasked <= (k < 2);
            nmi_req <= (k == 2);
            interrupt_accept_enable <= (k == 1);
            wait_ev(k == 0 ? 1 : 0, 2, 2);
            @(posedge clock);
            irq_unmasked <= 1'b0;
            nmi_req <= 1'b0;
        end
    endtask
    task automatic t_stop;
        go_stop(3'h0, 1'b1);
        repeat (5) @(negedge clock);
        rd(16'hFFFB, 8'h04);
        unstop(0, 1'b1, 4096 + DLY, 4096 + DLY + 6);
        go_stop(3'h2, 1'b1);
        unstop(1, 1'b0, MID + DLY, MID + DLY + 6);
        go_stop(3'h4, 1'b0);
        unstop(1, 1'b0, LONG + DLY, LONG + DLY + 6);
    endtask
    task automatic t_pending;
        @(posedge clock);
        irq_unmasked <= 1'b1;
        interrupt_accept_enable <= 1'b0;
        pulse(1);
        chk({13'h0000, osc_enable, cpu_run, port_latch_hold},
            16'h0004);
        wait_ev(1, LONG - 4, LONG + DLY + 6);
        @(posedge clock);
        irq_unmasked <= 1'b0;
    endtask
    task automatic t_resets;
        go_stop(3'h2, 1'b0);
        pin_reset(4'b0010);
        wait_ev(2, MID + DLY, MID + DLY + 12);
        rd(SEL, 8'h04);
        pulse(2);
        chk({13'h0000, sys_reset, pins_hiz, cpu_run}, 16'h0006);
        wait_ev(2, MID, MID + 12);
        pulse(0);
        pin_reset(4'b1110);
        wait_ev(2, MID, MID + 12);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        t_power_up();
        t_select();
        t_halt();
        t_stop();
        t_pending();
        t_resets();
        test_done();
    end
endmodule
`default_nettype wire
